// >>> src/tbm_pkg.sv
package tbm_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int          ADDR_W   = 8;
  localparam int          DATA_W   = 32;
  localparam int          NUM_CH   = 6;
  localparam int          IDX_W    = 6;

  // ---------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [5:0]  IDX_PROTECT  = 6'h0a;
  localparam logic [5:0]  IDX_CLK_SRC  = 6'h12;
  localparam logic [5:0]  IDX_CLK_GATE = 6'h16;
  localparam logic [5:0]  IDX_START    = 6'h20;
  localparam logic [5:0]  IDX_RDSEL    = 6'h21;
  localparam logic [5:0]  IDX_MODE     = 6'h22;
  localparam logic [5:0]  IDX_CNT_BASE = 6'h30;
  localparam logic [5:0]  IDX_CAP_BASE = 6'h38;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int          SRC_TIMER_BIT  = 0;
  localparam int          SRC_SERIAL_BIT = 1;
  localparam int          SRC_CLKOUT_BIT = 5;
  localparam logic [7:0]  SRC_RST        = 8'h03;
  localparam logic [7:0]  SRC_MASK       = 8'h23;
  localparam logic [7:0]  GATE_RST       = 8'h00;
  localparam logic [7:0]  GATE_MASK      = 8'h77;
  localparam int          GATE_TIMER_BIT = 1;
  localparam int          PROT_BIT       = 0;
  localparam logic [15:0] CNT_RST        = 16'h0000;
  localparam logic [15:0] CNT_MAX        = 16'hffff;
  localparam logic [15:0] CNT_ONE        = 16'h0001;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  // channel operating modes, two bits per channel
  typedef enum logic [1:0]
  {
    MODE_EVT_PIN,
    MODE_PERIOD,
    MODE_WIDTH,
    MODE_EVT_CASCADE
  } tbm_mode_type;

endpackage : tbm_pkg

// >>> src/tbm_chan_if.sv
`timescale 1ns/10ps
interface tbm_chan_if;
  logic        start;
  logic [1:0]  mode;
  logic        tick;
  logic        cascadeIn;
  logic        wrEn;
  logic [15:0] wrData;
  logic [15:0] count;
  logic [15:0] capture;
  logic        overflow;

  modport ctl
  (
    output start, mode, tick, cascadeIn, wrEn, wrData,
    input  count, capture, overflow
  );

  modport chan
  (
    input  start, mode, tick, cascadeIn, wrEn, wrData,
    output count, capture, overflow
  );
endinterface : tbm_chan_if

// >>> src/tbm_channel.sv
`timescale 1ns/10ps
module tbm_channel
  import tbm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // measurement pin, asynchronous
  input wire logic pinIn,
  // control and results
  tbm_chan_if.chan ch
);

  logic         pinMeta;
  logic         pinSync;
  logic         pinLast;
  logic         armed;
  logic [15:0]  count;
  logic [15:0]  capture;
  logic         overflow;
  logic         next_armed;
  logic [15:0]  next_count;
  logic [15:0]  next_capture;
  logic         next_overflow;
  tbm_mode_type mode;
  logic         measure;
  logic         pinRise;
  logic         activeEdge;
  logic         evtStep;

  // ---------------------------------------------------------------
  // counter and capture
  // ---------------------------------------------------------------
  // edges are taken from pinSync and pinLast only; pinMeta feeds nothing else
  always_comb
  begin
    mode          = tbm_mode_type'(ch.mode);
    measure       = (mode == MODE_PERIOD) || (mode == MODE_WIDTH);
    pinRise       = pinSync & ~pinLast;
    activeEdge    = (mode == MODE_WIDTH) ? (pinSync ^ pinLast) : pinRise;
    evtStep       = (mode == MODE_EVT_PIN) ? pinRise : ch.cascadeIn;
    next_count    = count;
    next_capture  = capture;
    next_armed    = armed & ch.start;
    next_overflow = 1'b0;
    if (measure && ch.start)
    begin
      if (activeEdge)
      begin
        // first edge arms and restarts; later edges store then restart
        if (armed)
          next_capture = count;
        next_count = CNT_RST;
        next_armed = 1'b1;
      end
      else if (armed && ch.tick)
      begin
        next_count    = count + CNT_ONE;
        next_overflow = (count == CNT_MAX);
      end
    end
    else if (!measure && ch.start && evtStep)
    begin
      next_count    = count + CNT_ONE;
      next_overflow = (count == CNT_MAX);
    end
    // a running measurement locks out software loads
    if (ch.wrEn && !(measure && ch.start))
      next_count = ch.wrData;
  end

  // registers only
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pinMeta  <= 1'b0;
      pinSync  <= 1'b0;
      pinLast  <= 1'b0;
      armed    <= 1'b0;
      count    <= CNT_RST;
      capture  <= CNT_RST;
      overflow <= 1'b0;
    end
    else
    begin
      pinMeta  <= pinIn;
      pinSync  <= pinMeta;
      pinLast  <= pinSync;
      armed    <= next_armed;
      count    <= next_count;
      capture  <= next_capture;
      overflow <= next_overflow;
    end
  end

  assign ch.count    = count;
  assign ch.capture  = capture;
  assign ch.overflow = overflow;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_MEAS_RO: assert property (@(posedge clk_sys) disable iff (rst)
    (ch.wrEn && ch.start && measure && !activeEdge)
    |=> (count == $past(count) + {15'h0, $past(armed && ch.tick)}))
    else $error("counter loaded during running measurement");

  AST_CAPTURE: assert property (@(posedge clk_sys) disable iff (rst)
    (measure && ch.start && armed && activeEdge)
    |=> (capture == $past(count)))
    else $error("active edge did not store the count");

  AST_RESTART: assert property (@(posedge clk_sys) disable iff (rst)
    (measure && ch.start && activeEdge && !ch.wrEn)
    ##1 (ch.start && !activeEdge && !ch.wrEn) |=> (count <= CNT_ONE))
    else $error("counter did not restart after edge");

  AST_EVT_PIN: assert property (@(posedge clk_sys) disable iff (rst)
    (mode == MODE_EVT_PIN && ch.start && pinRise && !ch.wrEn)
    |=> (count == $past(count) + CNT_ONE))
    else $error("event pulse not counted");

endmodule : tbm_channel

// >>> src/tbm_top.sv
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
// Functional notes
// - timer clock select: 0 half rate, 1 full
// - serial clock select: 0 half rate, 1 full
// - clock out expansion 1 forces full rate
// - stop bit 1 withholds that peripheral clock
// - gate bits 3 and 7 unstored, read zero
// - event mode counts pin pulses or overflows
// - measuring counter ignores writes while started
// - edge starts count, next edge stores it
// - read select 0: counter read gives result
// - read select 1: counter read gives live
// - read select 1: capture register holds result
// - read select 0: capture register reads zero
module tbm_top
  import tbm_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // measurement pins
  input  wire logic [NUM_CH-1:0] timerMeasureInputPin,
  // clock steering
  output logic                   timerClockFullSel,
  output logic                   serialClockFullSel,
  output logic                   clockOutFullSel,
  output logic [5:0]             peripheralClockEnable
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic [IDX_W-1:0] idxOf(input logic [ADDR_W-1:0] a);
    idxOf = a[ADDR_W-1:2];
  endfunction : idxOf

  function automatic logic inRange(input logic [IDX_W-1:0] i,
                                   input logic [IDX_W-1:0] base);
    inRange = (i >= base) && (i < base + IDX_W'(NUM_CH));
  endfunction : inRange

  function automatic logic isMapped(input logic [IDX_W-1:0] i);
    isMapped = (i == IDX_PROTECT) || (i == IDX_CLK_SRC)
            || (i == IDX_CLK_GATE) || (i == IDX_START)
            || (i == IDX_RDSEL) || (i == IDX_MODE)
            || inRange(i, IDX_CNT_BASE) || inRange(i, IDX_CAP_BASE);
  endfunction : isMapped

  logic              awHeld;
  logic [ADDR_W-1:0] awAddr;
  logic              wHeld;
  logic [DATA_W-1:0] wData;
  logic [3:0]        wStrb;
  logic              next_awHeld;
  logic [ADDR_W-1:0] next_awAddr;
  logic              next_wHeld;
  logic [DATA_W-1:0] next_wData;
  logic [3:0]        next_wStrb;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_rvalid;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0]        next_rresp;
  logic              regWrite;
  logic [IDX_W-1:0]  wIdx;
  logic [IDX_W-1:0]  rIdx;
  logic [DATA_W-1:0] readValue;

  logic [7:0]        clkSrc;
  logic [7:0]        clkGate;
  logic              protect;
  logic [NUM_CH-1:0] startFlags;
  logic [NUM_CH-1:0] rdSel;
  logic [2*NUM_CH-1:0] modeBits;
  logic              halfPhase;
  logic [7:0]        next_clkSrc;
  logic [7:0]        next_clkGate;
  logic              next_protect;
  logic [NUM_CH-1:0] next_startFlags;
  logic [NUM_CH-1:0] next_rdSel;
  logic [2*NUM_CH-1:0] next_modeBits;
  logic              timerTick;
  logic              lowByte;

  logic [15:0]       cntVal [NUM_CH];
  logic [15:0]       capVal [NUM_CH];
  logic [NUM_CH-1:0] ovf;

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  // one write and one read in flight; address and data in any order
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign regWrite      = awHeld && wHeld && !s_axi_bvalid;
  assign wIdx          = idxOf(awAddr);
  assign rIdx          = idxOf(s_axi_araddr);

  // read mux; unmapped words read zero
  always_comb
  begin
    readValue = '0;
    if (rIdx == IDX_PROTECT)
      readValue[PROT_BIT] = protect;
    else if (rIdx == IDX_CLK_SRC)
      readValue[7:0] = clkSrc;
    else if (rIdx == IDX_CLK_GATE)
      readValue[7:0] = clkGate & GATE_MASK;
    else if (rIdx == IDX_START)
      readValue[NUM_CH-1:0] = startFlags;
    else if (rIdx == IDX_RDSEL)
      readValue[NUM_CH-1:0] = rdSel;
    else if (rIdx == IDX_MODE)
      readValue[2*NUM_CH-1:0] = modeBits;
    for (int i = 0; i < NUM_CH; i++)
    begin
      // select chooses result or live count
      if (rIdx == IDX_CNT_BASE + IDX_W'(i))
        readValue[15:0] = rdSel[i] ? cntVal[i] : capVal[i];
      // capture word is meaningless under select 0, so zero
      if (rIdx == IDX_CAP_BASE + IDX_W'(i))
        readValue[15:0] = rdSel[i] ? capVal[i] : CNT_RST;
    end
  end

  // channel handshakes and response
  always_comb
  begin
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld  = wHeld;
    next_wData  = wData;
    next_wStrb  = wStrb;
    next_bvalid = s_axi_bvalid;
    next_bresp  = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (regWrite)
    begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = isMapped(wIdx) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rdata  = readValue;
      next_rresp  = isMapped(rIdx) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
  end

  // registers only
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      awHeld       <= 1'b0;
      awAddr       <= '0;
      wHeld        <= 1'b0;
      wData        <= '0;
      wStrb        <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else
    begin
      awHeld       <= next_awHeld;
      awAddr       <= next_awAddr;
      wHeld        <= next_wHeld;
      wData        <= next_wData;
      wStrb        <= next_wStrb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // byte registers need lane 0; clock words also need the unlock
  always_comb
  begin
    lowByte         = regWrite && wStrb[0];
    next_clkSrc     = clkSrc;
    next_clkGate    = clkGate;
    next_protect    = protect;
    next_startFlags = startFlags;
    next_rdSel      = rdSel;
    next_modeBits   = modeBits;
    if (lowByte && wIdx == IDX_PROTECT)
      next_protect = wData[PROT_BIT];
    if (lowByte && protect && wIdx == IDX_CLK_SRC)
      next_clkSrc = wData[7:0] & SRC_MASK;
    if (lowByte && protect && wIdx == IDX_CLK_GATE)
      next_clkGate = wData[7:0] & GATE_MASK;
    if (lowByte && wIdx == IDX_START)
      next_startFlags = wData[NUM_CH-1:0];
    if (lowByte && wIdx == IDX_RDSEL)
      next_rdSel = wData[NUM_CH-1:0];
    if (regWrite && wStrb[1:0] == 2'b11 && wIdx == IDX_MODE)
      next_modeBits = wData[2*NUM_CH-1:0];
  end

  // registers only
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      clkSrc     <= SRC_RST;
      clkGate    <= GATE_RST;
      protect    <= 1'b0;
      startFlags <= '0;
      rdSel      <= '0;
      modeBits   <= '0;
      halfPhase  <= 1'b0;
    end
    else
    begin
      clkSrc     <= next_clkSrc;
      clkGate    <= next_clkGate;
      protect    <= next_protect;
      startFlags <= next_startFlags;
      rdSel      <= next_rdSel;
      modeBits   <= next_modeBits;
      halfPhase  <= !halfPhase;
    end
  end

  // clock steering; the tick stands in for the gated timer clock
  assign timerClockFullSel  = clkSrc[SRC_TIMER_BIT];
  assign serialClockFullSel = clkSrc[SRC_SERIAL_BIT];
  assign clockOutFullSel    = clkSrc[SRC_CLKOUT_BIT];
  assign peripheralClockEnable = ~{clkGate[6:4], clkGate[2:0]};
  assign timerTick = !clkGate[GATE_TIMER_BIT]
                  && (clkSrc[SRC_TIMER_BIT] || halfPhase);

  // ---------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NUM_CH; g++)
  begin : gen_ch
    tbm_chan_if chIf();

    assign chIf.start     = startFlags[g];
    assign chIf.mode      = modeBits[2*g +: 2];
    assign chIf.tick      = timerTick;
    // cascade from the previous channel, ring wraps at zero
    assign chIf.cascadeIn = ovf[(g + NUM_CH - 1) % NUM_CH];
    // only a full 16-bit write reaches the counter
    assign chIf.wrEn      = regWrite && wStrb[1:0] == 2'b11
                         && wIdx == IDX_CNT_BASE + IDX_W'(g);
    assign chIf.wrData    = wData[15:0];
    assign cntVal[g]      = chIf.count;
    assign capVal[g]      = chIf.capture;
    assign ovf[g]         = chIf.overflow;

    tbm_channel u_channel
    (
      .clk_sys (clk_sys),
      .rst     (rst),
      .pinIn   (timerMeasureInputPin[g]),
      .ch      (chIf.chan)
    );
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_HALF_RATE: assert property (@(posedge clk_sys) disable iff (rst)
    (!clkSrc[SRC_TIMER_BIT] && !clkGate[GATE_TIMER_BIT] && timerTick
     && $stable(clkSrc) && $stable(clkGate)
     && !(lowByte && protect && wIdx == IDX_CLK_SRC)) |=> !timerTick)
    else $error("half rate tick ran at full rate");

  AST_SER_SEL: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(serialClockFullSel)
    |-> $past(regWrite && protect && wIdx == IDX_CLK_SRC))
    else $error("serial clock select moved without write");

  AST_CLKOUT: assert property (@(posedge clk_sys) disable iff (rst)
    (lowByte && protect && wIdx == IDX_CLK_SRC)
    |=> (clockOutFullSel == $past(wData[SRC_CLKOUT_BIT])))
    else $error("clock out expansion not taken");

  AST_STOP: assert property (@(posedge clk_sys) disable iff (rst)
    clkGate[GATE_TIMER_BIT] |-> (!timerTick && !peripheralClockEnable[1]))
    else $error("stopped timer clock still ticking");

  AST_PROTECT: assert property (@(posedge clk_sys) disable iff (rst)
    (regWrite && wIdx == IDX_CLK_GATE && !protect) |=> $stable(clkGate))
    else $error("clock gate written while locked");

  AST_GATE_RSV: assert property (@(posedge clk_sys) disable iff (rst)
    (s_axi_arvalid && s_axi_arready && rIdx == IDX_CLK_GATE)
    |=> (s_axi_rdata[3] == 1'b0 && s_axi_rdata[7] == 1'b0))
    else $error("unstored gate bits read nonzero");

  AST_RD_RESULT: assert property (@(posedge clk_sys) disable iff (rst)
    (s_axi_arvalid && s_axi_arready && rIdx == IDX_CNT_BASE && !rdSel[0])
    |=> (s_axi_rdata[15:0] == $past(capVal[0])))
    else $error("counter read did not give result");

  AST_RD_LIVE: assert property (@(posedge clk_sys) disable iff (rst)
    (s_axi_arvalid && s_axi_arready && rIdx == IDX_CNT_BASE && rdSel[0])
    |=> (s_axi_rdata[15:0] == $past(cntVal[0])))
    else $error("counter read did not give live count");

  AST_CAP_UNDEF: assert property (@(posedge clk_sys) disable iff (rst)
    (s_axi_arvalid && s_axi_arready && rIdx == IDX_CAP_BASE && !rdSel[0])
    |=> (s_axi_rdata == '0))
    else $error("unused capture word read nonzero");

endmodule : tbm_top

// >>> bench/tbm_pulse_source.sv
`timescale 1ns/10ps
module tbm_pulse_source
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // pulse shape
  input  wire logic        run,
  input  wire logic [7:0]  highCycles,
  input  wire logic [7:0]  lowCycles,
  // pulse and its rising-edge tally
  output logic             pulse,
  output logic [15:0]      riseCount
);
  logic [7:0] phase;

  // pulse train while run is high; idles low so no stray edge
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst || !run)
    begin
      pulse <= 1'b0;
      phase <= 8'h00;
    end
    else if (phase == (pulse ? highCycles : lowCycles) - 8'h01)
    begin
      pulse <= !pulse;
      phase <= 8'h00;
      if (!pulse)
        riseCount <= riseCount + 16'h0001;
    end
    else
      phase <= phase + 8'h01;
    if (rst)
      riseCount <= 16'h0000;
  end
endmodule : tbm_pulse_source

// >>> bench/timer_b_measure_clock_select_tb.sv
`timescale 1ns/10ps
module timer_b_measure_clock_select_tb
  import tbm_pkg::*;
;
  // ---------------------------------------------------------------
  // stimulus and observation
  // ---------------------------------------------------------------
  typedef struct packed
  {
    logic [5:0] idx;
    logic [7:0] wr;
    logic [7:0] rd;
    logic [8:0] outs;
  } tbm_row_type;
  // outs = {timer full, serial full, clock out full, enables}
  localparam tbm_row_type ROWS [8] = '{
    '{IDX_CLK_SRC, 8'h23, 8'h23, 9'h1ff},
    '{IDX_CLK_SRC, 8'h20, 8'h20, 9'h07f},
    '{IDX_CLK_GATE, 8'h77, 8'h77, 9'h040},
    '{IDX_CLK_GATE, 8'h02, 8'h02, 9'h07d},
    '{IDX_CLK_GATE, 8'h00, 8'h00, 9'h07f},
    '{IDX_CLK_SRC, 8'h01, 8'h01, 9'h13f},
    '{IDX_RDSEL, 8'h37, 8'h37, 9'h13f},
    '{IDX_MODE, 8'h6c, 8'h6c, 9'h13f}};
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic [7:0]  awaddr  = 8'h00, araddr = 8'h00;
  logic [31:0] wdata   = 32'h0, rdata, rdv, c, a;
  logic [3:0]  wstrb   = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, run = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pulse;
  logic [1:0]  bresp, rresp, rsp;
  logic        tFull, sFull, oFull;
  logic [5:0]  clkEn;
  logic [15:0] rises;
  int          errors = 0, compares = 0, n;

  always #10 clk_sys = ~clk_sys;

  tbm_top u_tbm_top (.clk_sys(clk_sys), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timerMeasureInputPin({6{pulse}}), .timerClockFullSel(tFull),
    .serialClockFullSel(sFull), .clockOutFullSel(oFull),
    .peripheralClockEnable(clkEn));

  tbm_pulse_source u_tbm_pulse_source (.clk_sys(clk_sys), .rst(rst),
    .run(run), .highCycles(8'h03), .lowCycles(8'h05), .pulse(pulse),
    .riseCount(rises));

  // ---------------------------------------------------------------
  // reporting and bus tasks
  // ---------------------------------------------------------------
  task automatic conclude;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // tasks start and end just after a rising edge
  task automatic axiWr(input logic [5:0] idx, input logic [31:0] d);
    awaddr  <= {idx, 2'b00};
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int k = 0; k < 64; k++)
    begin
      @(posedge clk_sys);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        rsp = bresp;
        bready <= 1'b0;
        @(posedge clk_sys);
        return;
      end
    end
    chk("write answer", 0, 1);
    conclude();
  endtask : axiWr

  task automatic axiRd(input logic [5:0] idx);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int k = 0; k < 64; k++)
    begin
      @(posedge clk_sys);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        rdv = rdata;
        rsp = rresp;
        rready <= 1'b0;
        @(posedge clk_sys);
        return;
      end
    end
    chk("read answer", 0, 1);
    conclude();
  endtask : axiRd

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    axiWr(IDX_PROTECT, 32'h1);
    foreach (ROWS[i])
    begin
      axiWr(ROWS[i].idx, {24'h0, ROWS[i].wr});
      axiRd(ROWS[i].idx);
      chk("row reg", rdv, {24'h0, ROWS[i].rd});
      chk("row pins", {tFull, sFull, oFull, clkEn}, ROWS[i].outs);
    end
    $display("test register table done");
    // ch0 event from 0xfffe, ch1 counts ch0 wraps, ch2 width, ch3 period
    axiWr(IDX_CNT_BASE, 32'hfffe);
    axiWr(IDX_CNT_BASE + 6'd1, 32'h0);
    axiWr(IDX_CNT_BASE + 6'd3, 32'h0);
    axiWr(IDX_START, 32'h0f);
    run <= 1'b1;
    // stop between pulses so the last high phase is not cut short
    for (n = 0; n < 400 && (rises != 16'd6 || pulse); n++)
      @(posedge clk_sys);
    run <= 1'b0;
    chk("pulse count", rises, 16'd6);
    chk("pulse wait", n < 400, 1);
    if (n >= 400)
      conclude();
    repeat (4) @(posedge clk_sys);
    axiRd(IDX_CNT_BASE);
    chk("event count", rdv, 32'h0004);
    axiRd(IDX_CNT_BASE + 6'd1);
    chk("cascade count", rdv, 32'h0001);
    axiRd(IDX_CNT_BASE + 6'd3);
    c = rdv;
    // period of 8 cycles, restarted at each rising edge
    chk("period", c == 32'h7 || c == 32'h8, 1);
    axiRd(IDX_CAP_BASE + 6'd2);
    // high phase of 3 cycles, restarted at the rising edge
    chk("width", rdv == 32'h2 || rdv == 32'h3, 1);
    axiRd(IDX_CAP_BASE + 6'd3);
    chk("capture hidden", rdv, 32'h0);
    axiWr(IDX_RDSEL, 32'h3f);
    axiRd(IDX_CAP_BASE + 6'd3);
    chk("capture shown", rdv, c);
    axiRd(IDX_CNT_BASE + 6'd3);
    a = rdv;
    axiRd(IDX_CNT_BASE + 6'd3);
    chk("live count", a > c && rdv > a, 1);
    axiWr(IDX_CNT_BASE + 6'd3, 32'habcd);
    axiWr(IDX_START, 32'h0);
    axiRd(IDX_CNT_BASE + 6'd3);
    chk("locked counter", rdv == 32'habcd, 0);
    axiWr(IDX_CNT_BASE + 6'd3, 32'habcd);
    axiRd(IDX_CNT_BASE + 6'd3);
    chk("stopped counter", rdv, 32'habcd);
    $display("test measurement done");
    // second reset: values return and protection closes
    rst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk("reset pins", {tFull, sFull, oFull, clkEn}, 9'h1bf);
    axiWr(IDX_CLK_SRC, 32'h0);
    axiRd(IDX_CLK_SRC);
    chk("locked source", rdv, {24'h0, SRC_RST});
    axiWr(IDX_CLK_GATE, 32'h77);
    axiRd(IDX_CLK_GATE);
    chk("locked gate", rdv, 32'h0);
    axiRd(IDX_CNT_BASE);
    chk("reset result", rdv, 32'h0);
    axiRd(IDX_CAP_BASE);
    chk("reset capture", rdv, 32'h0);
    $display("test reset and protect done");
    axiRd(6'h3f);
    chk("unmapped read", {rdv[29:0], rsp}, {30'h0, RESP_SLVERR});
    axiWr(6'h3f, 32'h1);
    chk("unmapped write", rsp, RESP_SLVERR);
    $display("test unmapped done");
    conclude();
  end
endmodule : timer_b_measure_clock_select_tb
